// ==== hvseq_defs.svh ====
`ifndef HVSEQ_DEFS_SVH
`define HVSEQ_DEFS_SVH

// timebase
`define HVSEQ_CLK_MHZ 100
`define HVSEQ_TICK_MS 1000
`define HVSEQ_TICK_W 27

// delays in seconds; +1 tick so a least time is never cut short
`define HVSEQ_QUAL_S 5
`define HVSEQ_STAG_S 5
`define HVSEQ_LEAD_S 10
`define HVSEQ_POST_S 90
`define HVSEQ_QUAL_TICKS (3'(`HVSEQ_QUAL_S + 1))
`define HVSEQ_STAG_TICKS (3'(`HVSEQ_STAG_S + 1))
`define HVSEQ_LEAD_TICKS (7'(`HVSEQ_LEAD_S + 1))
`define HVSEQ_POST_TICKS (7'(`HVSEQ_POST_S + 1))

// reduced indoor speed share
`define HVSEQ_PCT_NUM 16'd80
`define HVSEQ_PCT_DEN 16'd100

// request count and local-control address
`define HVSEQ_NREQ 5
`define HVSEQ_ADDR_LOCAL 4'h0

// register byte offsets
`define HVSEQ_REG_CTRL 8'h00
`define HVSEQ_REG_SPEED 8'h04
`define HVSEQ_REG_STATUS 8'h08

// speed reset values
`define HVSEQ_SPD_Y1_RST 8'h99
`define HVSEQ_SPD_Y2_RST 8'hcc
`define HVSEQ_SPD_OFM_RST 8'hff

`endif

// ==== hvseq_pkg.sv ====
`include "hvseq_defs.svh"

package hvseq_pkg;

  typedef struct packed {
    logic second_step_cool_request;
    logic first_step_cool_request;
    logic heat_request;
    logic moisture_removal_request;
    logic fan_only_request;
  } hvseq_req_t;

  typedef struct packed {
    logic [7:0] ofm;
    logic [7:0] y2;
    logic [7:0] y1;
  } hvseq_spd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN = 2'b11,
    ST_POST = 2'b10
  } hvseq_state_t;

  typedef struct packed {
    logic [`HVSEQ_TICK_W-1:0] cnt;
    logic tick;
  } hvseq_tick_st_t;

  typedef struct packed {
    logic [`HVSEQ_NREQ-1:0][2:0] cnt;
    logic [`HVSEQ_NREQ-1:0] q;
  } hvseq_qual_st_t;

  typedef struct packed {
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic ack;
    logic [31:0] rdat;
    hvseq_req_t net;
    hvseq_spd_t spd;
    hvseq_state_t fsm;
    logic [6:0] tmr;
    logic [2:0] stag;
    logic [7:0] hold;
    logic [7:0] fan;
    logic [7:0] ofm;
    logic cc1;
    logic cc2;
    logic heat;
    logic lead_ok;
    logic last_op;
  } hvseq_top_st_t;

endpackage

// ==== hvseq_tick.sv ====
`timescale 1ns/1ps
`include "hvseq_defs.svh"

module hvseq_tick
  import hvseq_pkg::*;
#(
  parameter int TICK_CYCLES = `HVSEQ_TICK_MS * 1000 * `HVSEQ_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // one-cycle pulse per second
  output logic tick
);

  hvseq_tick_st_t r;
  hvseq_tick_st_t n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt == `HVSEQ_TICK_W'(TICK_CYCLES - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + `HVSEQ_TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule // hvseq_tick

// ==== hvseq_qual.sv ====
`timescale 1ns/1ps
`include "hvseq_defs.svh"

module hvseq_qual
  import hvseq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic tick,
  // raw and qualified requests
  input wire hvseq_req_t raw,
  output hvseq_req_t qual
);

  hvseq_qual_st_t r;
  hvseq_qual_st_t n;
  logic [`HVSEQ_NREQ-1:0] rv;
  logic [`HVSEQ_NREQ-1:0][2:0] nc;
  logic [`HVSEQ_NREQ-1:0] nq;

  assign rv = raw;

  // any drop restarts the count, so only continuous requests qualify
  for (genvar i = 0; i < `HVSEQ_NREQ; i++) begin : g_req
    assign nc[i] = !rv[i] ? 3'h0 :
                   (tick && r.cnt[i] != `HVSEQ_QUAL_TICKS) ?
                   r.cnt[i] + 3'h1 : r.cnt[i];
    assign nq[i] = (nc[i] == `HVSEQ_QUAL_TICKS);
  end

  always_comb begin
    n = r;
    n.cnt = nc;
    n.q = nq;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign qual = hvseq_req_t'(r.q);

endmodule // hvseq_qual

// ==== hvseq_top.sv ====
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "hvseq_defs.svh"

module hvseq_top
  import hvseq_pkg::*;
#(
  parameter int TICK_CYCLES = `HVSEQ_TICK_MS * 1000 * `HVSEQ_CLK_MHZ
) (
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // board pins
  input wire hvseq_req_t THERMO_REQ,
  input wire logic [3:0] NET_ADDR,
  input wire logic FAN_CYCLE_SWITCH_IN,
  input wire logic SUPPLY_OK,
  input wire logic FAULT_ACTIVE,
  // drives
  output logic COMPRESSOR_ONE_OUT,
  output logic COMPRESSOR_TWO_OUT,
  output logic HEATER_OUT,
  output logic [7:0] INDOOR_FAN_SPEED,
  output logic [7:0] OUTDOOR_FAN_SPEED
);

  localparam hvseq_top_st_t TOP_RST = '{
    sync1: '0, sync2: '0, ack: 1'b0, rdat: '0, net: '0,
    spd: '{ofm: `HVSEQ_SPD_OFM_RST, y2: `HVSEQ_SPD_Y2_RST,
           y1: `HVSEQ_SPD_Y1_RST},
    fsm: ST_IDLE, tmr: '0, stag: '0, hold: '0, fan: '0, ofm: '0,
    cc1: 1'b0, cc2: 1'b0, heat: 1'b0, lead_ok: 1'b0, last_op: 1'b0};

  hvseq_top_st_t r;
  hvseq_top_st_t n;
  hvseq_req_t pin_req;
  hvseq_req_t src;
  hvseq_req_t q;
  logic [3:0] addr_s;
  logic fcc_s, sup_s, flt_s, tick;
  logic cool, heat_w, op_any, any_req, normal, run_now;
  logic cc1_want, cc2_want, bus_wr;
  logic [7:0] spd80, want;
  logic [31:0] rd_word, wr_word;
  logic [4:0] qv, srcv;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // two-stage synchronised pins
  assign pin_req = hvseq_req_t'(r.sync2[4:0]);
  assign addr_s = r.sync2[8:5];
  assign fcc_s = r.sync2[9];
  assign sup_s = r.sync2[10];
  assign flt_s = r.sync2[11];
  assign src = (addr_s == `HVSEQ_ADDR_LOCAL) ? pin_req : r.net;

  hvseq_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(CLK_SYS),
    .sys_rst(SYS_RST),
    .clk_en(CLK_EN),
    .tick(tick)
  );

  hvseq_qual u_qual (
    .clk_sys(CLK_SYS),
    .sys_rst(SYS_RST),
    .clk_en(CLK_EN),
    .tick(tick),
    .raw(src),
    .qual(q)
  );

  assign qv = q;
  assign srcv = src;

  // arbitration; cooling masks heat so compressors and heater never mix
  assign cool = q.first_step_cool_request | q.second_step_cool_request;
  assign heat_w = q.heat_request & ~cool;
  assign op_any = cool | q.heat_request | q.moisture_removal_request;
  assign any_req = op_any | q.fan_only_request;
  assign normal = sup_s & ~flt_s;

  assign spd80 = 8'((16'(r.spd.y2) * `HVSEQ_PCT_NUM) / `HVSEQ_PCT_DEN);
  assign want = q.second_step_cool_request ? r.spd.y2 :
                q.first_step_cool_request ? r.spd.y1 :
                (q.heat_request | q.moisture_removal_request) ? spd80 :
                q.fan_only_request ? r.spd.y2 : 8'h00;

  // register file
  assign bus_wr = WB_CYC_I & WB_STB_I & WB_WE_I & r.ack;
  always_comb begin
    case ({WB_ADR_I[7:2], 2'b00})
      `HVSEQ_REG_CTRL: rd_word = {27'h0, r.net};
      `HVSEQ_REG_SPEED: rd_word = {8'h00, r.spd};
      `HVSEQ_REG_STATUS: rd_word = {15'h0, addr_s, fcc_s, flt_s, sup_s,
                                    r.fsm, r.heat, r.cc2, r.cc1, qv};
      default: rd_word = 32'h0;
    endcase
  end
  assign wr_word = wmerge(rd_word, WB_DAT_I, WB_SEL_I);

  always_comb begin
    n = r;
    n.sync1 = {FAULT_ACTIVE, SUPPLY_OK, FAN_CYCLE_SWITCH_IN, NET_ADDR,
               THERMO_REQ};
    n.sync2 = r.sync1;
    n.ack = WB_CYC_I & WB_STB_I & ~r.ack;
    if (n.ack) begin
      n.rdat = rd_word;
    end
    if (bus_wr) begin
      case ({WB_ADR_I[7:2], 2'b00})
        `HVSEQ_REG_CTRL: n.net = hvseq_req_t'(wr_word[4:0]);
        `HVSEQ_REG_SPEED: n.spd = hvseq_spd_t'(wr_word[23:0]);
        default: n.ack = n.ack;
      endcase
    end

    // indoor fan sequencer
    case (r.fsm)
      ST_IDLE: begin
        if (heat_w) begin
          n.fsm = ST_LEAD;
          n.tmr = `HVSEQ_LEAD_TICKS;
        end else if (any_req) begin
          n.fsm = ST_RUN;
        end
      end
      ST_LEAD: begin
        if (!any_req) begin
          n.fsm = ST_POST;
          n.tmr = `HVSEQ_POST_TICKS;
        end else if (!heat_w) begin
          n.fsm = ST_RUN;
        end else if (r.tmr == 7'h0) begin
          n.fsm = ST_RUN;
          n.lead_ok = 1'b1;
        end else if (tick) begin
          n.tmr = r.tmr - 7'h1;
        end
      end
      ST_RUN: begin
        if (!any_req) begin
          // lone fan stops at once; real operations get the post-run
          n.fsm = r.last_op ? ST_POST : ST_IDLE;
          n.tmr = `HVSEQ_POST_TICKS;
        end else if (heat_w && !r.lead_ok) begin
          n.fsm = ST_LEAD;
          n.tmr = `HVSEQ_LEAD_TICKS;
        end
      end
      ST_POST: begin
        if (any_req) begin
          n.fsm = heat_w ? ST_LEAD : ST_RUN;
          n.tmr = `HVSEQ_LEAD_TICKS;
        end else if (r.tmr == 7'h0) begin
          n.fsm = ST_IDLE;
        end else if (tick) begin
          n.tmr = r.tmr - 7'h1;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase
    if (!heat_w) begin
      n.lead_ok = 1'b0;
    end
    if (n.fsm == ST_RUN || n.fsm == ST_LEAD) begin
      n.last_op = op_any;
      n.hold = want;
    end

    // compressors, staggered against inrush
    run_now = (n.fsm == ST_RUN);
    cc1_want = normal & run_now & q.first_step_cool_request;
    cc2_want = normal & run_now & q.second_step_cool_request;
    n.cc1 = cc1_want & (r.cc1 | (r.stag == 3'h0));
    n.cc2 = cc2_want & (r.cc2 |
            ((r.stag == 3'h0) & ~(cc1_want & ~r.cc1)));
    if ((n.cc1 & ~r.cc1) | (n.cc2 & ~r.cc2)) begin
      n.stag = `HVSEQ_STAG_TICKS;
    end else if (tick && r.stag != 3'h0) begin
      n.stag = r.stag - 3'h1;
    end

    // heater: single stage, only after the fan lead, never with compressors
    n.heat = normal & run_now & heat_w & n.lead_ok &
             ~n.cc1 & ~n.cc2;
    n.fan = (sup_s && n.fsm != ST_IDLE) ? n.hold : 8'h00;
    n.ofm = ((n.cc1 | n.cc2) & fcc_s) ? r.spd.ofm : 8'h00;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      r <= TOP_RST;
    end else if (CLK_EN) begin
      r <= n;
    end
  end

  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.rdat;
  assign COMPRESSOR_ONE_OUT = r.cc1;
  assign COMPRESSOR_TWO_OUT = r.cc2;
  assign HEATER_OUT = r.heat;
  assign INDOOR_FAN_SPEED = r.fan;
  assign OUTDOOR_FAN_SPEED = r.ofm;

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  property p_excl;
    !(r.heat && (r.cc1 || r.cc2));
  endproperty
  a_excl: assert property (p_excl)
    else $error("heater on with a compressor");

  property p_no_twin;
    !($rose(r.cc1) && $rose(r.cc2));
  endproperty
  a_no_twin: assert property (p_no_twin)
    else $error("compressors closed together");

  property p_stag_wait;
    ($rose(r.cc1) || $rose(r.cc2)) |-> $past(r.stag) == '0;
  endproperty
  a_stag_wait: assert property (p_stag_wait)
    else $error("compressor started inside stagger window");

  property p_supply;
    (!sup_s && CLK_EN) |=> (!r.cc1 && !r.cc2 && !r.heat &&
                            r.fan == '0 && r.ofm == '0);
  endproperty
  a_supply: assert property (p_supply)
    else $error("output energised without supply");

  property p_fault;
    (flt_s && CLK_EN) |=> (!r.cc1 && !r.cc2 && !r.heat);
  endproperty
  a_fault: assert property (p_fault)
    else $error("load energised during fault");

  property p_qual;
    CLK_EN |=> (qv & ~$past(srcv)) == '0;
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualified request without raw request");

  property p_heat_lead;
    $rose(r.heat) |-> r.lead_ok && r.fsm == ST_RUN;
  endproperty
  a_heat_lead: assert property (p_heat_lead)
    else $error("heater on before fan lead");

  property p_ofm;
    r.ofm != '0 |-> (r.cc1 || r.cc2) && $past(fcc_s);
  endproperty
  a_ofm: assert property (p_ofm)
    else $error("outdoor fan without cooling or switch");

  property p_post;
    r.fsm == ST_POST |-> (!r.cc1 && !r.cc2 && !r.heat && r.ofm == '0);
  endproperty
  a_post: assert property (p_post)
    else $error("load still on during post-run");

  property p_prio;
    r.heat |-> !$past(q.first_step_cool_request) &&
               !$past(q.second_step_cool_request);
  endproperty
  a_prio: assert property (p_prio)
    else $error("heater won over cooling");

  property p_speed2;
    (CLK_EN && sup_s && r.fsm == ST_RUN && q.second_step_cool_request)
      |=> r.fan == $past(r.spd.y2);
  endproperty
  a_speed2: assert property (p_speed2)
    else $error("wrong fan speed for stage two");

  property p_fan_only;
    (CLK_EN && sup_s && r.fsm == ST_RUN && q.fan_only_request && !op_any)
      |=> r.fan == $past(r.spd.y2);
  endproperty
  a_fan_only: assert property (p_fan_only)
    else $error("wrong fan speed for lone fan");

  property p_cc1;
    r.cc1 |-> $past(q.first_step_cool_request);
  endproperty
  a_cc1: assert property (p_cc1)
    else $error("compressor one without request");

  c_heat: cover property ($rose(r.heat));
  c_full: cover property (r.cc1 && r.cc2);
  c_post_end: cover property (r.fsm == ST_POST ##1 r.fsm == ST_IDLE);
  c_fan_only: cover property (r.fsm == ST_RUN && qv == 5'h01);

endmodule // hvseq_top

// ==== hvseq_room.sv ====
`timescale 1ns/1ps

module hvseq_room
  import hvseq_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // commands from the bench
  input wire hvseq_req_t cmd,
  input wire logic sw_cmd,
  // loads as the equipment sees them
  input wire logic cc1,
  input wire logic cc2,
  // contacts towards the board, capacity back to the bench
  output hvseq_req_t contacts,
  output logic fan_switch,
  output logic [1:0] capacity
);
  // contacts bounce in one cycle late, like a slow thermostat
  always_ff @(posedge clk_sys) begin
    contacts <= cmd;
    fan_switch <= sw_cmd;
  end

  // staged pair: the second stage alone cools nothing
  always_comb begin
    capacity = 2'(cc1) + 2'(cc1 & cc2);
  end
endmodule // hvseq_room

// ==== testbench.sv ====
`timescale 1ns/1ps

module testbench
  import hvseq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  hvseq_req_t req_cmd = '0;
  hvseq_req_t thermo;
  logic sw_cmd = 1'b0;
  logic fcs;
  logic [3:0] net_addr = 4'h0;
  logic supply_ok = 1'b1;
  logic fault = 1'b0;
  logic cc1, cc2, htr;
  logic [7:0] ifan, ofan;
  logic [1:0] cap;
  logic [31:0] q;
  int miscompares = 0;
  int checked = 0;
  int cyc_cnt = 0;
  wire [3:0] obs = {cc1, cc2, htr, |ifan};

  always #5 clk_sys = ~clk_sys;

  hvseq_top #(.TICK_CYCLES(20)) u_dut (.CLK_SYS(clk_sys),
    .SYS_RST(sys_rst), .CLK_EN(clk_en), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
    .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r),
    .WB_ACK_O(wb_ack), .THERMO_REQ(thermo), .NET_ADDR(net_addr),
    .FAN_CYCLE_SWITCH_IN(fcs), .SUPPLY_OK(supply_ok),
    .FAULT_ACTIVE(fault), .COMPRESSOR_ONE_OUT(cc1),
    .COMPRESSOR_TWO_OUT(cc2), .HEATER_OUT(htr),
    .INDOOR_FAN_SPEED(ifan), .OUTDOOR_FAN_SPEED(ofan));

  hvseq_room u_room (.clk_sys(clk_sys), .cmd(req_cmd), .sw_cmd(sw_cmd),
    .cc1(cc1), .cc2(cc2), .contacts(thermo), .fan_switch(fcs),
    .capacity(cap));

  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // counts cycles until an output reaches a level, then judges the count
  task wait_obs(input string nm, input int k, input logic v, input int lo,
                input int hi);
    int n;
    n = 0;
    while (obs[k] !== v && n <= hi) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(nm, 32'h1, {31'h0, (n >= lo && n <= hi)});
  endtask

  // request held until ack is seen high at a rising edge, released there
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack !== 1'b1 && t < 20);
    chk("wb ack", 32'h1, {31'h0, wb_ack});
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task set_req(input hvseq_req_t r);
    @(posedge clk_sys);
    req_cmd <= r;
  endtask

  task t_regs;
    wb(1'b0, 8'h04, 32'h0);
    chk("speed reset", 32'h00ffcc99, q);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, 8'h08, 32'hffffffff);
    wb(1'b0, 8'h08, 32'h0);
    chk("status idle", 32'h400, {19'h0, q[12:0]});
  endtask

  task t_cool;
    set_req(5'h18);
    sw_cmd <= 1'b1;
    step(95);
    chk("cc1 early", 32'h0, {31'h0, cc1});
    wait_obs("cc1 on", 3, 1'b1, 0, 40);
    wait_obs("cc2 stagger", 2, 1'b1, 95, 125);
    chk("fan y2", 32'hcc, {24'h0, ifan});
    chk("ofm on", 32'hff, {24'h0, ofan});
    chk("capacity", 32'h2, {30'h0, cap});
    @(posedge clk_sys);
    sw_cmd <= 1'b0;
    step(8);
    chk("ofm off", 32'h0, {24'h0, ofan});
    set_req(5'h08);
    step(8);
    chk("cc2 off", 32'h0, {31'h0, cc2});
    chk("fan y1", 32'h99, {24'h0, ifan});
    chk("partial", 32'h1, {30'h0, cap});
    set_req(5'h00);
    step(8);
    chk("cc1 drop", 32'h0, {31'h0, cc1});
    chk("fan post", 32'h99, {24'h0, ifan});
    wait_obs("post end", 0, 1'b0, 1780, 1840);
  endtask

  task t_heat;
    set_req(5'h04);
    wait_obs("fan lead", 0, 1'b1, 95, 135);
    chk("fan heat", 32'ha3, {24'h0, ifan});
    wait_obs("heat delay", 1, 1'b1, 195, 230);
    step(300);
    chk("heat held", 32'h1, {31'h0, htr});
    set_req(5'h00);
    step(8);
    chk("heat drop", 32'h0, {31'h0, htr});
    step(400);
    chk("heat post", 32'ha3, {24'h0, ifan});
    set_req(5'h01);
    step(140);
    chk("post cut", 32'hcc, {24'h0, ifan});
    set_req(5'h00);
    step(8);
    chk("fan only end", 32'h0, {24'h0, ifan});
  endtask

  task t_prio;
    set_req(5'h0f);
    wait_obs("y1 wins", 3, 1'b1, 95, 135);
    step(300);
    chk("no heater", 32'h0, {31'h0, htr});
    chk("fan prio", 32'h99, {24'h0, ifan});
    set_req(5'h00);
    wait_obs("prio post", 0, 1'b0, 1790, 1850);
  endtask

  task t_fault;
    set_req(5'h08);
    fault <= 1'b1;
    step(140);
    chk("fault cc1", 32'h0, {31'h0, cc1});
    chk("fault fan", 32'h99, {24'h0, ifan});
    @(posedge clk_sys);
    supply_ok <= 1'b0;
    step(8);
    chk("supply fan", 32'h0, {24'h0, ifan});
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    fault <= 1'b0;
    supply_ok <= 1'b1;
    req_cmd <= 5'h00;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    step(2);
    chk("reset fan", 32'h0, {24'h0, ifan});
  endtask

  task t_net;
    set_req(5'h08);
    net_addr <= 4'h1;
    wb(1'b1, 8'h00, 32'h01);
    step(140);
    chk("pins ignored", 32'h0, {31'h0, cc1});
    chk("net fan", 32'hcc, {24'h0, ifan});
    wb(1'b1, 8'h00, 32'h0);
    step(8);
    chk("net fan off", 32'h0, {24'h0, ifan});
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    step(1);
    t_regs();
    t_cool();
    t_heat();
    t_prio();
    t_fault();
    t_net();
    end_sim();
  end
endmodule // testbench
